// ==== design/ifr_follower.sv ====
// Follower end: decodes bus sessions into register read and write accesses
`default_nettype none
module ifr_follower (
  input wire logic i_link_clk,
  input wire logic i_rst_n,
  ifr_bus_if.follower bus,
  input wire logic i_host_port_select,
  input wire logic i_chip_sel_hi,
  input wire logic i_chip_sel_lo,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_req,
  output logic o_wr_stb,
  output logic [9:0] o_reg_addr,
  output logic [7:0] o_wr_data,
  output logic o_busy
);

  ifr_pkg::ifr_dev_state_type state_reg;
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic [3:0] cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [9:0] addr_reg;
  logic rw_reg;
  logic ack_due_reg;
  logic sda_oe_reg;
  logic busy_reg;
  logic rd_req_reg;
  logic wr_stb_reg;
  logic [9:0] out_addr_reg;
  logic [7:0] wr_data_reg;

  logic scl_now;
  logic sda_now;
  logic enabled;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic byte_done;
  logic ack_rise;
  logic [7:0] rx_next;
  logic chip_match;
  logic [2:0] tx_idx;

  // Bus pins pass two flops at the link sampling clock
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_reg <= 5'h1f;
      pin_s2_reg <= 5'h1f;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      pin_s1_reg <= {bus.scl, bus.sda, i_host_port_select, i_chip_sel_hi, i_chip_sel_lo};
      pin_s2_reg <= pin_s1_reg;
      scl_prev_reg <= pin_s2_reg[4];
      sda_prev_reg <= pin_s2_reg[3];
    end
  end

  assign scl_now = pin_s2_reg[4];
  assign sda_now = pin_s2_reg[3];
  // Port active only with select low
  assign enabled = ~pin_s2_reg[2];
  assign start_det = scl_now & scl_prev_reg & sda_prev_reg & ~sda_now;
  assign stop_det = scl_now & scl_prev_reg & ~sda_prev_reg & sda_now;
  assign scl_rise = scl_now & ~scl_prev_reg;
  assign scl_fall = ~scl_now & scl_prev_reg;
  assign byte_done = scl_rise & (cnt_reg == ifr_pkg::BIT_LAST_DATA);
  assign ack_rise = scl_rise & (cnt_reg == ifr_pkg::BIT_ACK_SLOT);
  assign rx_next = {rx_reg[6:0], sda_now};
  // Select pins fill the low chip bits
  assign chip_match = (rx_next[7:3] == {ifr_pkg::CHIP_FIXED_HI, pin_s2_reg[1:0]}) ||
                      (rx_next[7:3] == ifr_pkg::CHIP_BROADCAST);
  assign tx_idx = (cnt_reg == ifr_pkg::BIT_ACK_DONE) ? 3'h7 : ~cnt_reg[2:0];

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg <= 1'b0;
    end else if (stop_det || !enabled) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end
  end

  // Session state
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ifr_pkg::DEV_IDLE;
    end else if (!enabled || stop_det) begin
      state_reg <= ifr_pkg::DEV_IDLE;
    end else if (start_det) begin
      // Repeated start begins a new address phase
      state_reg <= ifr_pkg::DEV_ADDR_HI;
    end else if (byte_done) begin
      unique case (state_reg)
        ifr_pkg::DEV_ADDR_HI: begin
          // Foreign address ignored until next start
          state_reg <= chip_match ? ifr_pkg::DEV_ADDR_LO : ifr_pkg::DEV_SKIP;
        end
        ifr_pkg::DEV_ADDR_LO: begin
          state_reg <= rw_reg ? ifr_pkg::DEV_READ : ifr_pkg::DEV_WRITE;
        end
        ifr_pkg::DEV_IDLE, ifr_pkg::DEV_WRITE, ifr_pkg::DEV_READ, ifr_pkg::DEV_SKIP: begin
          state_reg <= state_reg;
        end
      endcase
    end else if (ack_rise && state_reg == ifr_pkg::DEV_READ && sda_now) begin
      state_reg <= ifr_pkg::DEV_SKIP;
    end
  end

  // Bit counter: 1..8 data bits, 9 after ack pulse
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= ifr_pkg::BIT_RST;
    end else if (start_det || stop_det || !enabled) begin
      cnt_reg <= ifr_pkg::BIT_RST;
    end else if (scl_rise && cnt_reg != ifr_pkg::BIT_ACK_DONE) begin
      cnt_reg <= cnt_reg + 4'h1;
    end else if (scl_fall && cnt_reg == ifr_pkg::BIT_ACK_DONE) begin
      cnt_reg <= ifr_pkg::BIT_RST;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_reg <= ifr_pkg::BYTE_RST;
    end else if (scl_rise && cnt_reg < ifr_pkg::BIT_ACK_SLOT) begin
      rx_reg <= rx_next;
    end
  end

  // Byte decode, address tracking and access strobes
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_reg <= ifr_pkg::REG_ADDR_RST;
      out_addr_reg <= ifr_pkg::REG_ADDR_RST;
      wr_data_reg <= ifr_pkg::BYTE_RST;
      rw_reg <= 1'b0;
      ack_due_reg <= 1'b0;
      rd_req_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
    end else begin
      rd_req_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      if (byte_done && enabled && !start_det && !stop_det) begin
        ack_due_reg <= 1'b0;
        unique case (state_reg)
          ifr_pkg::DEV_ADDR_HI: begin
            ack_due_reg <= chip_match;
            if (chip_match) begin
              // High address bits from byte one
              addr_reg[9:8] <= rx_next[2:1];
              rw_reg <= rx_next[0];
            end
          end
          ifr_pkg::DEV_ADDR_LO: begin
            // Low address bits from byte two
            ack_due_reg <= 1'b1;
            if (rw_reg) begin
              out_addr_reg <= {addr_reg[9:8], rx_next};
              addr_reg <= {addr_reg[9:8], rx_next} + 10'h001;
              rd_req_reg <= 1'b1;
            end else begin
              addr_reg <= {addr_reg[9:8], rx_next};
            end
          end
          ifr_pkg::DEV_WRITE: begin
            ack_due_reg <= 1'b1;
            out_addr_reg <= addr_reg;
            addr_reg <= addr_reg + 10'h001;
            wr_data_reg <= rx_next;
            wr_stb_reg <= 1'b1;
          end
          ifr_pkg::DEV_IDLE, ifr_pkg::DEV_READ, ifr_pkg::DEV_SKIP: begin
            ack_due_reg <= 1'b0;
          end
        endcase
      end else if (ack_rise && state_reg == ifr_pkg::DEV_READ && !sda_now && !ack_due_reg) begin
        // Acked read fetches next register
        // Own ack of the address byte is not a leader ack
        out_addr_reg <= addr_reg;
        addr_reg <= addr_reg + 10'h001;
        rd_req_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_reg <= ifr_pkg::BYTE_RST;
    end else if (rd_req_reg) begin
      tx_reg <= i_rd_data;
    end
  end

  // Data line drive, set only after a clock fall, released on start, stop or port disable
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_oe_reg <= 1'b0;
    end else if (!enabled || start_det || stop_det) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      if (cnt_reg == ifr_pkg::BIT_ACK_SLOT) begin
        // Ack low through the ninth pulse
        sda_oe_reg <= ack_due_reg;
      end else begin
        // Read bits set while clock low
        sda_oe_reg <= (state_reg == ifr_pkg::DEV_READ) & ~tx_reg[tx_idx];
      end
    end
  end

  assign bus.sda_do_fol = 1'b0;
  assign bus.sda_oe_fol = sda_oe_reg;
  assign o_rd_req = rd_req_reg;
  assign o_wr_stb = wr_stb_reg;
  assign o_reg_addr = out_addr_reg;
  assign o_wr_data = wr_data_reg;
  assign o_busy = busy_reg;

endmodule
`default_nettype wire

// ==== design/ifr_pkg.sv ====
// Constants and state types shared by the follower and leader ends of the link
`default_nettype none
package ifr_pkg;
  localparam logic [2:0] CHIP_FIXED_HI = 3'h4;
  localparam logic [4:0] CHIP_BROADCAST = 5'h15;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE = 4'h9;
  localparam logic [3:0] BIT_RST = 4'h0;
  localparam logic [9:0] REG_ADDR_RST = 10'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam int REF_PERIOD_NS = 25;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QUARTER_CYC = (SCL_PERIOD_NS + 4 * REF_PERIOD_NS - 1) / (4 * REF_PERIOD_NS);
  localparam logic [4:0] QUARTER_MAX = 5'(QUARTER_CYC - 1);
  localparam logic [4:0] QUARTER_RST = 5'h00;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_ADDR_HI = 3'h1,
    DEV_ADDR_LO = 3'h3,
    DEV_WRITE = 3'h2,
    DEV_READ = 3'h6,
    DEV_SKIP = 3'h7
  } ifr_dev_state_type;
  typedef enum logic [1:0] {
    LDR_IDLE = 2'h0,
    LDR_START = 2'h1,
    LDR_XFER = 2'h3,
    LDR_STOP = 2'h2
  } ifr_ldr_state_type;
endpackage
`default_nettype wire

// ==== design/ifr_bus_if.sv ====
// Open-drain two-wire bus joining the leader and follower ends
`default_nettype none
interface ifr_bus_if;
  logic scl_do_ldr;
  logic scl_oe_ldr;
  logic sda_do_ldr;
  logic sda_oe_ldr;
  logic sda_do_fol;
  logic sda_oe_fol;
  logic scl;
  logic sda;
  // Pull-ups hold both lines high unless a driver is enabled
  assign scl = scl_oe_ldr ? scl_do_ldr : 1'b1;
  assign sda = (sda_oe_ldr ? sda_do_ldr : 1'b1) & (sda_oe_fol ? sda_do_fol : 1'b1);
  modport leader (output scl_do_ldr, scl_oe_ldr, sda_do_ldr, sda_oe_ldr, input scl, sda);
  modport follower (output sda_do_fol, sda_oe_fol, input scl, sda);
endinterface
`default_nettype wire

// ==== design/ifr_leader.sv ====
// Leader end: runs one register read or write session on the two-wire bus
`default_nettype none
module ifr_leader (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ifr_bus_if.leader bus,
  input wire logic i_go,
  input wire logic i_rw,
  input wire logic [4:0] i_chip_addr,
  input wire logic [9:0] i_reg_addr,
  input wire logic [3:0] i_len,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_take,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_busy,
  output logic o_done,
  output logic o_nack
);

  ifr_pkg::ifr_ldr_state_type state_reg;
  logic [4:0] q_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [3:0] byte_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic wr_take_reg;
  logic done_reg;
  logic nack_reg;
  logic rw_reg;
  logic [4:0] chip_reg;
  logic [9:0] addr_reg;
  logic [3:0] len_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic [1:0] sda_sync_reg;
  logic tick;
  logic rx_byte;
  logic last_byte;
  logic sda_in;

  assign tick = (q_reg == ifr_pkg::QUARTER_MAX);
  assign rx_byte = rw_reg & (byte_reg > 4'h1);
  assign last_byte = ({1'b0, byte_reg} == {1'b0, len_reg} + 5'h01);
  assign sda_in = sda_sync_reg[1];

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_sync_reg <= 2'h3;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_reg <= ifr_pkg::QUARTER_RST;
    end else if (state_reg == ifr_pkg::LDR_IDLE || tick) begin
      q_reg <= ifr_pkg::QUARTER_RST;
    end else begin
      q_reg <= q_reg + 5'h01;
    end
  end

  // Leader sequences start, bytes and stop
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ifr_pkg::LDR_IDLE;
      ph_reg <= ifr_pkg::PHASE_RST;
      bit_reg <= ifr_pkg::BIT_RST;
      byte_reg <= 4'h0;
      tx_reg <= ifr_pkg::BYTE_RST;
      rx_reg <= ifr_pkg::BYTE_RST;
      rd_data_reg <= ifr_pkg::BYTE_RST;
      rd_valid_reg <= 1'b0;
      wr_take_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
      rw_reg <= 1'b0;
      chip_reg <= 5'h00;
      addr_reg <= ifr_pkg::REG_ADDR_RST;
      len_reg <= 4'h0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      rd_valid_reg <= 1'b0;
      wr_take_reg <= 1'b0;
      done_reg <= 1'b0;
      if (state_reg == ifr_pkg::LDR_IDLE) begin
        if (i_go) begin
          state_reg <= ifr_pkg::LDR_START;
          ph_reg <= ifr_pkg::PHASE_RST;
          rw_reg <= i_rw;
          chip_reg <= i_chip_addr;
          addr_reg <= i_reg_addr;
          len_reg <= i_len;
          nack_reg <= 1'b0;
        end
      end else if (tick) begin
        ph_reg <= ph_reg + 2'h1;
        unique case (state_reg)
          ifr_pkg::LDR_START: begin
            if (ph_reg == 2'h0) sda_oe_reg <= 1'b1;
            if (ph_reg == 2'h2) scl_oe_reg <= 1'b1;
            if (ph_reg == 2'h3) begin
              state_reg <= ifr_pkg::LDR_XFER;
              bit_reg <= ifr_pkg::BIT_RST;
              byte_reg <= 4'h0;
              tx_reg <= {chip_reg, addr_reg[9:8], rw_reg};
            end
          end
          ifr_pkg::LDR_XFER: begin
            unique case (ph_reg)
              2'h0: begin
                if (bit_reg < ifr_pkg::BIT_ACK_SLOT) begin
                  sda_oe_reg <= ~rx_byte & ~tx_reg[~bit_reg[2:0]];
                end else begin
                  sda_oe_reg <= rx_byte & ~last_byte;
                end
              end
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: begin
                if (bit_reg < ifr_pkg::BIT_ACK_SLOT && rx_byte) begin
                  rx_reg <= {rx_reg[6:0], sda_in};
                end
                if (bit_reg == ifr_pkg::BIT_LAST_DATA && rx_byte) begin
                  rd_data_reg <= {rx_reg[6:0], sda_in};
                  rd_valid_reg <= 1'b1;
                end
                if (bit_reg == ifr_pkg::BIT_ACK_SLOT && !rx_byte && sda_in) begin
                  nack_reg <= 1'b1;
                end
              end
              2'h3: begin
                scl_oe_reg <= 1'b1;
                if (bit_reg != ifr_pkg::BIT_ACK_SLOT) begin
                  bit_reg <= bit_reg + 4'h1;
                end else if (nack_reg || last_byte) begin
                  // Each session covers one consecutive run
                  state_reg <= ifr_pkg::LDR_STOP;
                end else begin
                  bit_reg <= ifr_pkg::BIT_RST;
                  byte_reg <= byte_reg + 4'h1;
                  if (byte_reg == 4'h0) begin
                    tx_reg <= addr_reg[7:0];
                  end else begin
                    tx_reg <= i_wr_data;
                    wr_take_reg <= ~rw_reg;
                  end
                end
              end
            endcase
          end
          ifr_pkg::LDR_STOP: begin
            if (ph_reg == 2'h0) sda_oe_reg <= 1'b1;
            if (ph_reg == 2'h1) scl_oe_reg <= 1'b0;
            if (ph_reg == 2'h2) sda_oe_reg <= 1'b0;
            if (ph_reg == 2'h3) begin
              state_reg <= ifr_pkg::LDR_IDLE;
              done_reg <= 1'b1;
            end
          end
          ifr_pkg::LDR_IDLE: begin
            state_reg <= ifr_pkg::LDR_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.scl_do_ldr = 1'b0;
  assign bus.scl_oe_ldr = scl_oe_reg;
  assign bus.sda_do_ldr = 1'b0;
  assign bus.sda_oe_ldr = sda_oe_reg;
  assign o_wr_take = wr_take_reg;
  assign o_rd_data = rd_data_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_busy = (state_reg != ifr_pkg::LDR_IDLE);
  assign o_done = done_reg;
  assign o_nack = nack_reg;

endmodule
`default_nettype wire

// ==== dv/ifr_link_assertions.sv ====
// Checker watching the two-wire link between leader and follower ends
`default_nettype none
module ifr_link_assertions (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_ldr,
  input wire logic sda_oe_ldr,
  input wire logic sda_oe_fol
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q, sda_q, busy_reg, rd_reg, acked_reg;
  logic [3:0] cnt_reg;
  logic [3:0] byte_reg;
  wire logic start_w = scl && scl_q && sda_q && !sda;
  wire logic stop_w = scl && scl_q && !sda_q && sda;
  wire logic rise_w = scl && !scl_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg <= 1'b0;
    end else if (start_w) begin
      busy_reg <= 1'b1;
    end else if (stop_w) begin
      busy_reg <= 1'b0;
    end
  end
  // Bit position within a byte and byte number within a session
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 4'h0;
      byte_reg <= 4'h0;
    end else if (start_w) begin
      cnt_reg <= 4'h0;
      byte_reg <= 4'h0;
    end else if (rise_w) begin
      cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
      if (cnt_reg == 4'h8 && byte_reg != 4'hf) begin
        byte_reg <= byte_reg + 4'h1;
      end
    end
  end
  // Direction bit and address acknowledge of the first byte
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_reg <= 1'b0;
      acked_reg <= 1'b0;
    end else if (rise_w && byte_reg == 4'h0 && cnt_reg == 4'h7) begin
      rd_reg <= sda;
    end else if (rise_w && byte_reg == 4'h0 && cnt_reg == 4'h8) begin
      acked_reg <= !sda;
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence ninth_s;
    $rose(scl) && cnt_reg == 4'h8;
  endsequence
  sequence start_s;
    $rose(sda_oe_ldr) && !scl_oe_ldr;
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  ack_byte_low_a: assert property (ninth_s ##0 (byte_reg != 4'h0 && acked_reg
    && (byte_reg == 4'h1 || !rd_reg)) |-> !sda) else $error("received byte not acked");
  rd_ack_free_a: assert property (ninth_s ##0 (byte_reg >= 4'h2 && rd_reg)
    |-> !sda_oe_fol) else $error("follower drives read ack slot");
  ldr_ack_free_a: assert property (ninth_s ##0 !(rd_reg && byte_reg >= 4'h2)
    |-> !sda_oe_ldr) else $error("leader drives ack slot");
  fol_hold_high_a: assert property (scl && $past(scl) |-> $stable(sda_oe_fol))
    else $error("follower data moved while clock high");
  idle_quiet_a: assert property (!busy_reg |-> !sda_oe_fol)
    else $error("follower drives outside a session");
  foreign_quiet_a: assert property (busy_reg && byte_reg != 4'h0 && !acked_reg
    |-> !sda_oe_fol) else $error("follower drives after foreign address");
  start_order_a: assert property (start_s |-> ##[45:55] $rose(scl_oe_ldr))
    else $error("start not followed by clock low");
  stop_idle_a: assert property (stop_s |-> ##1 (sda && scl && !sda_oe_fol) [*8])
    else $error("lines not idle after stop");
  clk_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule
`default_nettype wire

// ==== dv/i2c_follower_reg_access_tb.sv ====
// Testbench joining leader and follower ends over the two-wire link
`default_nettype none
module i2c_follower_reg_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_link_clk, i_rst_n, i_go, i_rw, i_host_port_select;
  logic [4:0] i_chip_addr;
  logic [9:0] i_reg_addr;
  logic [3:0] i_len;
  logic [7:0] l_wr_data, l_rd_data, f_rd_data, f_wr_data;
  logic [9:0] f_addr;
  logic l_take, l_rd_valid, l_done, l_nack, f_wr_stb, f_busy, busy_seen;
  logic l_busy, f_rd_req, i_chip_sel_hi, i_chip_sel_lo;
  int err_total, n_compared, wi;
  logic [17:0] wq[$];
  logic [7:0] rq[$];
  logic [9:0] aq[$];
  ifr_bus_if bus_if();
  ifr_leader i_ifr_leader (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(bus_if),
    .i_go(i_go), .i_rw(i_rw), .i_chip_addr(i_chip_addr), .i_reg_addr(i_reg_addr),
    .i_len(i_len), .i_wr_data(l_wr_data), .o_wr_take(l_take), .o_rd_data(l_rd_data),
    .o_rd_valid(l_rd_valid), .o_busy(l_busy), .o_done(l_done), .o_nack(l_nack));
  ifr_follower i_ifr_follower (.i_link_clk(i_link_clk), .i_rst_n(i_rst_n), .bus(bus_if),
    .i_host_port_select(i_host_port_select), .i_chip_sel_hi(i_chip_sel_hi),
    .i_chip_sel_lo(i_chip_sel_lo), .i_rd_data(f_rd_data), .o_rd_req(f_rd_req),
    .o_wr_stb(f_wr_stb), .o_reg_addr(f_addr),
    .o_wr_data(f_wr_data), .o_busy(f_busy));
  ifr_link_assertions i_ifr_link_assertions (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .scl(bus_if.scl), .sda(bus_if.sda), .scl_oe_ldr(bus_if.scl_oe_ldr),
    .sda_oe_ldr(bus_if.sda_oe_ldr), .sda_oe_fol(bus_if.sda_oe_fol));
  function automatic logic [7:0] wdat(input int k);
    return 8'(8'ha5 + k * 8'h3b);
  endfunction
  function automatic logic [7:0] rdat(input logic [9:0] a);
    return a[7:0] ^ {6'h16, a[9:8]};
  endfunction
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #7;
    forever #40 i_link_clk = ~i_link_clk;
  end
  // Next write byte is presented once the current one was taken
  always @(negedge i_ref_clk) begin
    if (l_take === 1'b1) wi = wi + 1;
    l_wr_data = wdat(wi);
  end
  // Register file stand-in on the follower's user side
  always @(negedge i_link_clk) f_rd_data <= rdat(f_addr);
  always @(negedge i_link_clk) begin
    if (f_wr_stb === 1'b1) wq.push_back({f_addr, f_wr_data});
    if (f_rd_req === 1'b1) aq.push_back(f_addr);
    if (f_busy === 1'b1) busy_seen = 1'b1;
  end
  always @(negedge i_ref_clk) begin
    if (l_rd_valid === 1'b1) rq.push_back(l_rd_data);
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic run(input logic rw, input logic [4:0] chip, input logic [9:0] addr,
    input logic [3:0] len);
    int n;
    @(negedge i_ref_clk);
    i_rw = rw;
    i_chip_addr = chip;
    i_reg_addr = addr;
    i_len = len;
    i_go = 1'b1;
    @(negedge i_ref_clk);
    i_go = 1'b0;
    check(18'(l_busy), 18'h1);
    n = 0;
    while (l_done !== 1'b1 && n < 40000) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 40000) err_total++;
    repeat (20) @(negedge i_ref_clk);
    check(18'(l_busy), 18'h0);
  endtask
  task automatic t_write_burst();
    wi = 0;
    wq.delete();
    busy_seen = 1'b0;
    run(1'b0, 5'h12, 10'h3fe, 4'h3);
    check(18'(l_nack), 18'h0);
    check(18'(busy_seen), 18'h1);
    check(18'(f_busy), 18'h0);
    check(18'(wq.size()), 18'h3);
    for (int k = 0; k < 3; k++) begin
      check(wq[k], {10'(10'h3fe + k), wdat(k)});
    end
  endtask
  task automatic t_read_burst();
    rq.delete();
    wq.delete();
    aq.delete();
    run(1'b1, 5'h15, 10'h1fe, 4'h3);
    check(18'(aq.size()), 18'h3);
    check(18'(l_nack), 18'h0);
    check(18'(wq.size()), 18'h0);
    check(18'(rq.size()), 18'h3);
    for (int k = 0; k < 3; k++) begin
      check(18'(rq[k]), 18'(rdat(10'(10'h1fe + k))));
      check(18'(aq[k]), 18'(10'(10'h1fe + k)));
    end
  endtask
  task automatic t_foreign_chip();
    wq.delete();
    run(1'b0, 5'h11, 10'h020, 4'h1);
    check(18'(l_nack), 18'h1);
    check(18'(wq.size()), 18'h0);
    // Same chip address is accepted once the select pins name it
    i_chip_sel_hi = 1'b0;
    i_chip_sel_lo = 1'b1;
    wi = 0;
    repeat (20) @(negedge i_ref_clk);
    run(1'b0, 5'h11, 10'h020, 4'h1);
    check(18'(l_nack), 18'h0);
    check(18'(wq.size()), 18'h1);
    check(wq[0], {10'h020, wdat(0)});
    i_chip_sel_hi = 1'b1;
    i_chip_sel_lo = 1'b0;
    repeat (20) @(negedge i_ref_clk);
  endtask
  task automatic t_port_off();
    wq.delete();
    busy_seen = 1'b0;
    i_host_port_select = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    run(1'b0, 5'h12, 10'h040, 4'h1);
    check(18'(l_nack), 18'h1);
    check(18'(busy_seen), 18'h0);
    check(18'(wq.size()), 18'h0);
    i_host_port_select = 1'b0;
    repeat (20) @(negedge i_ref_clk);
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_go = 1'b0;
    i_rw = 1'b0;
    i_chip_addr = 5'h00;
    i_reg_addr = 10'h000;
    i_len = 4'h0;
    i_chip_sel_hi = 1'b1;
    i_chip_sel_lo = 1'b0;
    i_host_port_select = 1'b0;
    l_wr_data = 8'h00;
    f_rd_data = 8'h00;
    busy_seen = 1'b0;
    err_total = 0;
    n_compared = 0;
    wi = 0;
    repeat (20) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    t_write_burst();
    t_read_burst();
    t_foreign_chip();
    t_port_off();
    finish_test();
  end
  // Sessions need well under a millisecond in total
  initial begin
    #2000000;
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
